// File: verilog/ext_clock_select.sv
// Overview of operation
// - select one routes external clock, zero internal
// - termination only while external input selected
// - external clock may stop; no edge timeout
// - band register holds one of five codes
// - two-band sets: only lowest and small
// - wider sets use all five bands
// - divider divides external clock by factor
// - divider accepts only the listed factors
module ext_clock_select (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // clock sources
  input wire logic i_ext_clk_pin,
  input wire logic i_int_tick,
  // channel setup
  input wire logic [3:0] i_chan_enable,
  input wire logic i_fifo_mode,
  // clock path outputs
  output logic o_sample_tick,
  output logic o_ext_clock_select,
  output logic o_clock_input_termination,
  output logic [ext_clk_pkg::BAND_W-1:0] o_ext_clock_band,
  output logic o_band_ok
);

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic select_q;
  logic term_q;
  logic [ext_clk_pkg::DIV_W-1:0] div_q;
  logic [ext_clk_pkg::BAND_W-1:0] band_q;
  logic ext_level;
  logic ext_level_q;
  logic ext_edge;
  logic div_tick;
  logic two_band;
  logic band_ok_d;

  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  logic req;
  logic commit_wr;
  logic [15:0] idx;
  logic [31:0] cur_val;
  logic [31:0] wr_val;

  assign req = i_wb_cyc && i_wb_stb;
  assign idx = i_wb_adr[17:2];
  // writes land on the edge where the master sees ack
  assign commit_wr = req && i_wb_we && o_wb_ack;

  always_comb begin
    cur_val = 32'h0000_0000;
    unique case (idx)
      ext_clk_pkg::IDX_DIVIDER: cur_val = {21'h00_0000, div_q};
      ext_clk_pkg::IDX_SELECT: cur_val[ext_clk_pkg::SELECT_BIT] = select_q;
      ext_clk_pkg::IDX_TERM: cur_val[ext_clk_pkg::TERM_BIT] = term_q;
      ext_clk_pkg::IDX_BAND: cur_val = {26'h000_0000, band_q};
      ext_clk_pkg::IDX_STATUS: begin
        cur_val[ext_clk_pkg::STAT_SEL_BIT] = select_q;
        cur_val[ext_clk_pkg::STAT_TERM_BIT] = o_clock_input_termination;
        cur_val[ext_clk_pkg::STAT_BAND_OK_BIT] = o_band_ok;
        cur_val[ext_clk_pkg::STAT_EXT_LEVEL_BIT] = ext_level;
      end
      default: cur_val = 32'h0000_0000;
    endcase
  end

  // byte lanes not enabled keep their present value
  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wr_val[8*b +: 8] = i_wb_sel[b] ? i_wb_dat[8*b +: 8] : cur_val[8*b +: 8];
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= req && !o_wb_ack;
    end
  end

  // unmapped reads return zero but still get ack
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (req && !o_wb_ack) begin
      o_wb_dat <= cur_val;
    end
  end

  // -----------------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      select_q <= ext_clk_pkg::RST_SELECT;
    end else if (commit_wr && idx == ext_clk_pkg::IDX_SELECT) begin
      select_q <= wr_val[ext_clk_pkg::SELECT_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      term_q <= ext_clk_pkg::RST_TERM;
    end else if (commit_wr && idx == ext_clk_pkg::IDX_TERM) begin
      term_q <= wr_val[ext_clk_pkg::TERM_BIT];
    end
  end

  // unlisted factors are dropped so the path never sees a bad divisor
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      div_q <= ext_clk_pkg::RST_DIVIDER;
    end else if (commit_wr && idx == ext_clk_pkg::IDX_DIVIDER
                 && ext_clk_pkg::div_allowed(wr_val)) begin
      div_q <= wr_val[ext_clk_pkg::DIV_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      band_q <= ext_clk_pkg::RST_BAND;
    end else if (commit_wr && idx == ext_clk_pkg::IDX_BAND
                 && ext_clk_pkg::band_allowed(wr_val)) begin
      band_q <= wr_val[ext_clk_pkg::BAND_W-1:0];
    end
  end

  // -----------------------------------------------------------------------
  // external clock path
  // -----------------------------------------------------------------------
  pin_sync u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_clk_pin),
    .o_level(ext_level)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ext_level_q <= 1'b0;
    end else begin
      ext_level_q <= ext_level;
    end
  end

  // pure edge detect, so a clock held still down to dc is legal
  assign ext_edge = ext_level && !ext_level_q;

  edge_divider u_edge_divider (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_edge(ext_edge),
    .i_factor(div_q),
    .o_tick(div_tick)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_sample_tick <= 1'b0;
    end else begin
      o_sample_tick <= select_q ? div_tick : i_int_tick;
    end
  end

  // -----------------------------------------------------------------------
  // pin controls
  // -----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_ext_clock_select <= ext_clk_pkg::RST_SELECT;
      o_clock_input_termination <= ext_clk_pkg::RST_TERM;
      o_ext_clock_band <= ext_clk_pkg::RST_BAND;
    end else begin
      o_ext_clock_select <= select_q;
      o_clock_input_termination <= term_q && select_q;
      o_ext_clock_band <= band_q;
    end
  end

  // -----------------------------------------------------------------------
  // band check against channel setup
  // -----------------------------------------------------------------------
  // the rate itself cannot be measured here; only the code is checked
  assign two_band = (i_chan_enable == ext_clk_pkg::CHAN_SINGLE)
                 || (i_chan_enable == ext_clk_pkg::CHAN_ZERO_TWO && !i_fifo_mode);

  always_comb begin
    if (two_band) begin
      band_ok_d = (band_q == ext_clk_pkg::BAND_LOWEST)
               || (band_q == ext_clk_pkg::BAND_SMALL);
    end else begin
      band_ok_d = ext_clk_pkg::band_allowed({26'h000_0000, band_q});
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_band_ok <= 1'b1;
    end else begin
      o_band_ok <= band_ok_d;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  sequence s_band_write_bad;
    commit_wr && idx == ext_clk_pkg::IDX_BAND
      && !ext_clk_pkg::band_allowed(wr_val);
  endsequence

  sequence s_div_write_bad;
    commit_wr && idx == ext_clk_pkg::IDX_DIVIDER
      && !ext_clk_pkg::div_allowed(wr_val);
  endsequence

  sequence s_select_on_write;
    commit_wr && idx == ext_clk_pkg::IDX_SELECT && wr_val[ext_clk_pkg::SELECT_BIT];
  endsequence

  // every external-mode cycle, not only the one after the select write
  a_select_routes: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    select_q |=> o_sample_tick == $past(div_tick))
    else $error("external tick not routed after select");

  a_internal_route: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !select_q |=> o_sample_tick == $past(i_int_tick))
    else $error("internal tick not routed");

  a_term_gated: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_clock_input_termination |-> $past(select_q) && $past(term_q))
    else $error("termination on without external input");

  a_band_legal: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ext_clk_pkg::band_allowed({26'h000_0000, band_q}) && $onehot(band_q))
    else $error("band register holds an illegal code");

  a_band_reject: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_band_write_bad |=> $stable(band_q))
    else $error("illegal band code was stored");

  a_div_legal: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ext_clk_pkg::div_allowed({21'h00_0000, div_q}))
    else $error("divider holds an unlisted factor");

  a_div_reject: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_div_write_bad |=> $stable(div_q))
    else $error("illegal divider factor was stored");

  a_reset_defaults: assert property (@(posedge i_ref_clk)
    !i_reset_n |=> !select_q && !term_q && div_q == ext_clk_pkg::RST_DIVIDER)
    else $error("reset defaults wrong");

  a_two_band_limit: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    two_band && band_q > ext_clk_pkg::BAND_SMALL |=> !o_band_ok)
    else $error("wide band accepted on two-band setup");

  a_wide_band_ok: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !two_band |=> o_band_ok)
    else $error("legal band flagged bad on five-band setup");

  // pin copies lag their register by one edge
  a_select_output: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_select_on_write |=> select_q ##1 o_ext_clock_select)
    else $error("select output did not follow the write");

  a_term_follows: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    select_q && term_q |=> o_clock_input_termination)
    else $error("termination not applied on external input");

  a_band_out_copy: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_ext_clock_band == $past(band_q))
    else $error("band output does not follow register");

  // a stuck-high pin must not look like a stream of edges
  a_edge_single: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ext_edge |=> !ext_edge)
    else $error("edge pulse longer than one cycle");

  a_ack_needs_req: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !req |=> !o_wb_ack)
    else $error("ack without a request");

  a_ack_single: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single cycle"); 

endmodule // ext_clock_select

// File: verilog/ext_clk_pkg.sv
package ext_clk_pkg;

  // -----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------------
  localparam logic [15:0] IDX_DIVIDER = 16'h4E48;
  localparam logic [15:0] IDX_SELECT = 16'h4E84;
  localparam logic [15:0] IDX_TERM = 16'h4E98;
  localparam logic [15:0] IDX_BAND = 16'h4EA2;
  localparam logic [15:0] IDX_STATUS = 16'h4EB0;

  // -----------------------------------------------------------------------
  // field layout
  // -----------------------------------------------------------------------
  localparam int DIV_W = 11;
  localparam int BAND_W = 6;
  localparam int SELECT_BIT = 0;
  localparam int TERM_BIT = 0;
  localparam int STAT_SEL_BIT = 0;
  localparam int STAT_TERM_BIT = 1;
  localparam int STAT_BAND_OK_BIT = 2;
  localparam int STAT_EXT_LEVEL_BIT = 3;

  // -----------------------------------------------------------------------
  // band codes
  // -----------------------------------------------------------------------
  localparam logic [BAND_W-1:0] BAND_LOWEST = 6'h02;
  localparam logic [BAND_W-1:0] BAND_SMALL = 6'h04;
  localparam logic [BAND_W-1:0] BAND_MEDIUM = 6'h08;
  localparam logic [BAND_W-1:0] BAND_LARGE = 6'h10;
  localparam logic [BAND_W-1:0] BAND_EXTRA_LARGE = 6'h20;

  // channel sets that only know two bands (CHAN_ZERO_TWO only while i_fifo_mode is low)
  localparam logic [3:0] CHAN_SINGLE = 4'h1;
  localparam logic [3:0] CHAN_ZERO_TWO = 4'h5;

  // -----------------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------------
  localparam logic RST_SELECT = 1'b0;
  localparam logic RST_TERM = 1'b0;
  localparam logic [DIV_W-1:0] RST_DIVIDER = 11'h001;
  localparam logic [BAND_W-1:0] RST_BAND = BAND_LOWEST;

  // -----------------------------------------------------------------------
  // legal divider factors
  // -----------------------------------------------------------------------
  function automatic logic div_allowed(input logic [31:0] f);
    unique case (f)
      32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
      32'h0000_000A, 32'h0000_0010, 32'h0000_0014, 32'h0000_0028,
      32'h0000_0032, 32'h0000_0050, 32'h0000_0064, 32'h0000_00C8,
      32'h0000_0190, 32'h0000_01F4, 32'h0000_0320, 32'h0000_03E8,
      32'h0000_07D0: div_allowed = 1'b1;
      default: div_allowed = 1'b0;
    endcase
  endfunction

  function automatic logic band_allowed(input logic [31:0] b);
    unique case (b)
      32'h0000_0002, 32'h0000_0004, 32'h0000_0008, 32'h0000_0010,
      32'h0000_0020: band_allowed = 1'b1;
      default: band_allowed = 1'b0;
    endcase
  endfunction

endpackage

// File: verilog/pin_sync.sv
module pin_sync (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // pin side
  input wire logic i_pin,
  // clock domain side
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level only moves once the two later stages agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_level <= 1'b0;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end

endmodule // pin_sync

// File: verilog/edge_divider.sv
module edge_divider (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // edge and factor
  input wire logic i_edge,
  input wire logic [ext_clk_pkg::DIV_W-1:0] i_factor,
  // divided tick
  output logic o_tick
);

  logic [ext_clk_pkg::DIV_W-1:0] count_q;
  logic wrap;

  // no timeout on the count: edges may stop for ever
  assign wrap = (count_q >= i_factor - ext_clk_pkg::DIV_W'(1));

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      count_q <= '0;
    end else if (i_edge) begin
      count_q <= wrap ? '0 : count_q + ext_clk_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_edge && wrap;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  a_tick_needs_edge: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_edge |=> !o_tick) else $error("tick without an input edge");

  a_div_wrap_tick: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_edge && wrap |=> o_tick && count_q == '0) else $error("divider did not wrap");

endmodule // edge_divider

// File: sim/ext_clock_source.sv
module ext_clock_source (
  // clock
  input wire logic i_ref_clk,
  // burst control
  input wire logic i_start,
  input wire logic [7:0] i_half,
  input wire logic [7:0] i_edges,
  // pin side
  output logic o_pin,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_q;
  logic [8:0] left_q;

  initial begin
    o_pin = 1'b0;
    cnt_q = 8'h00;
    left_q = 9'h000;
  end

  // ---------------------------------------------------------------------
  // clock burst
  // ---------------------------------------------------------------------
  // half period of 8 or more ref cycles keeps the rate well under the maximum
  // and, undivided at the bench's half period of 10, above 1 MS/s
  always @(posedge i_ref_clk) begin
    if (i_start) begin
      left_q <= {i_edges, 1'b0};
      cnt_q <= 8'h00;
    end else if (left_q != 9'h000) begin
      if (cnt_q == i_half - 8'h01) begin
        cnt_q <= 8'h00;
        o_pin <= ~o_pin;
        left_q <= left_q - 9'h001;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // pin rests low between bursts, so the clock may stop for any time
  assign o_busy = (left_q != 9'h000) || i_start;
endmodule // ext_clock_source

// File: sim/ext_clock_select_bench.sv
module ext_clock_select_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [17:0] i_wb_adr = 18'h00000;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic o_wb_ack;
  logic [31:0] o_wb_dat;
  logic ext_pin;
  logic i_int_tick = 1'b0;
  logic [3:0] i_chan_enable = 4'h1;
  logic i_fifo_mode = 1'b0;
  logic o_sample_tick;
  logic o_ext_clock_select;
  logic o_clock_input_termination;
  logic [5:0] o_ext_clock_band;
  logic o_band_ok;
  logic src_start = 1'b0;
  logic [7:0] src_edges = 8'h00;
  logic src_busy;
  int err_count = 0;
  int checks = 0;
  int ticks = 0;
  logic [31:0] rdat;
  int base;
  logic [31:0] divs [17] = '{1, 2, 4, 8, 10, 16, 20, 40, 50, 80, 100, 200, 400, 500, 800,
                             1000, 2000};

  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_sample_tick === 1'b1) ticks <= ticks + 1;

  ext_clock_select ext_clock_select_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_ext_clk_pin(ext_pin),
    .i_int_tick(i_int_tick), .i_chan_enable(i_chan_enable), .i_fifo_mode(i_fifo_mode),
    .o_sample_tick(o_sample_tick), .o_ext_clock_select(o_ext_clock_select),
    .o_clock_input_termination(o_clock_input_termination),
    .o_ext_clock_band(o_ext_clock_band), .o_band_ok(o_band_ok));

  ext_clock_source ext_clock_source_i (
    .i_ref_clk(i_ref_clk), .i_start(src_start), .i_half(8'h0A), .i_edges(src_edges),
    .o_pin(ext_pin), .o_busy(src_busy));

  // ---------------------------------------------------------------------
  // bench tasks
  // ---------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    rdat = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (n >= 20) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h00000000);
    chk(name, exp, rdat);
  endtask

  task automatic do_reset();
    i_reset_n <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
  endtask

  task automatic burst(input logic [7:0] n);
    int k;
    @(posedge i_ref_clk);
    src_edges <= n;
    src_start <= 1'b1;
    @(posedge i_ref_clk);
    src_start <= 1'b0;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (src_busy === 1'b1 && k < 5000);
    repeat (20) @(posedge i_ref_clk);
    if (k >= 5000) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic pulse_int();
    @(posedge i_ref_clk);
    i_int_tick <= 1'b1;
    @(posedge i_ref_clk);
    i_int_tick <= 1'b0;
  endtask

  task automatic band_case(input logic [3:0] ch, input logic fifo, input logic exp);
    @(posedge i_ref_clk);
    i_chan_enable <= ch;
    i_fifo_mode <= fifo;
    repeat (3) @(posedge i_ref_clk);
    chk("band_ok", {31'h0, exp}, {31'h0, o_band_ok});
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk("divider", ext_clk_pkg::IDX_DIVIDER, 32'h00000001);
    rd_chk("select", ext_clk_pkg::IDX_SELECT, 32'h00000000);
    rd_chk("term", ext_clk_pkg::IDX_TERM, 32'h00000000);
    rd_chk("unmapped", 16'h0100, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, ext_clk_pkg::IDX_BAND, 32'h2 << i);
      rd_chk("band", ext_clk_pkg::IDX_BAND, 32'h2 << i);
      chk("band_out", 32'h2 << i, {26'h0, o_ext_clock_band});
    end
    wb(1'b1, ext_clk_pkg::IDX_BAND, 32'h00000003);
    rd_chk("band_bad", ext_clk_pkg::IDX_BAND, 32'h00000020);
    foreach (divs[i]) begin
      wb(1'b1, ext_clk_pkg::IDX_DIVIDER, divs[i]);
      rd_chk("divider", ext_clk_pkg::IDX_DIVIDER, divs[i]);
    end
    wb(1'b1, ext_clk_pkg::IDX_DIVIDER, 32'h00000003);
    rd_chk("div_bad", ext_clk_pkg::IDX_DIVIDER, 32'h000007D0);
    wb(1'b1, ext_clk_pkg::IDX_DIVIDER, 32'h00000C00);
    rd_chk("div_big", ext_clk_pkg::IDX_DIVIDER, 32'h000007D0);
    // band legality by channel set, band 8 is only valid with five bands
    wb(1'b1, ext_clk_pkg::IDX_BAND, 32'h00000008);
    band_case(4'h1, 1'b0, 1'b0);
    band_case(4'h5, 1'b0, 1'b0);
    band_case(4'h5, 1'b1, 1'b1);
    band_case(4'h3, 1'b0, 1'b1);
    band_case(4'hF, 1'b1, 1'b1);
    wb(1'b1, ext_clk_pkg::IDX_BAND, 32'h00000004);
    band_case(4'h1, 1'b1, 1'b1);
    // termination needs the external input
    wb(1'b1, ext_clk_pkg::IDX_TERM, 32'h00000001);
    repeat (2) @(posedge i_ref_clk);
    chk("term_out", 32'h0, {31'h0, o_clock_input_termination});
    rd_chk("term", ext_clk_pkg::IDX_TERM, 32'h00000001);
    base = ticks;
    repeat (3) pulse_int();
    repeat (3) @(posedge i_ref_clk);
    chk("int_ticks", 32'h3, 32'(ticks - base));
    // fresh divider count for the external path
    do_reset();
    // source runs near 1.25 MS/s: lowest band for one channel
    wb(1'b1, ext_clk_pkg::IDX_BAND, 32'h00000002);
    wb(1'b1, ext_clk_pkg::IDX_DIVIDER, 32'h00000004);
    wb(1'b1, ext_clk_pkg::IDX_SELECT, 32'h00000001);
    repeat (2) @(posedge i_ref_clk);
    chk("sel_out", 32'h1, {31'h0, o_ext_clock_select});
    chk("term_out", 32'h0, {31'h0, o_clock_input_termination});
    wb(1'b1, ext_clk_pkg::IDX_TERM, 32'h00000001);
    repeat (2) @(posedge i_ref_clk);
    chk("term_out", 32'h1, {31'h0, o_clock_input_termination});
    // status is read only: the write must leave it alone
    wb(1'b1, ext_clk_pkg::IDX_STATUS, 32'h00000000);
    rd_chk("status", ext_clk_pkg::IDX_STATUS, 32'h00000007);
    base = ticks;
    burst(8'h08);
    chk("ext_ticks", 32'h2, 32'(ticks - base));
    // clock stopped a long time and internal ticks arrive: no sample tick
    repeat (3) pulse_int();
    repeat (300) @(posedge i_ref_clk);
    chk("stall_ticks", 32'h2, 32'(ticks - base));
    burst(8'h04);
    chk("ext_ticks", 32'h3, 32'(ticks - base));
    wb(1'b1, ext_clk_pkg::IDX_SELECT, 32'h00000000);
    burst(8'h08);
    chk("int_only", 32'h3, 32'(ticks - base));
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge i_ref_clk);
    err_count++;
    stop_test();
  end
endmodule // ext_clock_select_bench
